// ---- disc_port_regs.svh ----
`ifndef DISC_PORT_REGS_SVH
`define DISC_PORT_REGS_SVH
//
// Notes on behaviour
// - host alone drives six address lines
// - status byte bus is two-way
// - write: address, data, select low, strobe
// - read: device drives value during strobe
// - sector bytes move one per handshake
// - host presents first byte before request
// - outbound request only when sector reached
// - host pulses outbound strobe on request
// - handshakes repeat until count satisfied
// - disc reads use inbound request, strobe
// - device drives requests, host drives strobes
// - transceiver drives out only on reads
// - decode uses address, strobes, select only
// - decode PROM, controller, four, two test
// - PROM 512 bytes, 32-byte fields
// - four-bit switch picks one of sixteen fields
// - self-test register read-only
// - control register write-only, lamp outputs
// - error register readable, faults and DMA
// - overflow register read and write
// - data error shows in error bit 5
// - control bit selects long ECC mode
//
// ----------
// device address map
// ----------
`define ADDR_CTRL_BASE 6'h00
`define ADDR_PROM_BASE 6'h20
`define ADDR_SELFTEST 6'h10
`define ADDR_GENCTL 6'h11
`define ADDR_ERRORS 6'h12
`define ADDR_OVERFLOW 6'h13
`define ADDR_TEST_A 6'h14
`define ADDR_TEST_B 6'h15
`define CTRL_REG_COUNT 16
`define PROM_BYTES 512
`define FIELD_BYTES 32
// ----------
// field positions
// ----------
`define GC_FAULT_BIT 0
`define GC_ONLINE_BIT 1
`define GC_LONG_ECC_BIT 2
`define ERR_DATA_BIT 5
`define ERR_XFER_BIT 0
`define ERR_DONE_BIT 1
`define CTRL_COUNT_REG 4'h2
`define CTRL_CMD_REG 4'h7
// ----------
// avalon map of the host end
// ----------
`define AV_REG_ADDR 3'h0
`define AV_REG_DATA 3'h1
`define AV_REG_CMD 3'h2
`define AV_REG_STATUS 3'h3
`define AV_REG_SECTOR 3'h4
`define AV_CMD_READ 2'h1
`define AV_CMD_WRITE 2'h2
`endif

// ---- disc_port_pkg.sv ----
package disc_port_pkg;
    typedef enum logic [1:0] {XFER_IDLE, XFER_OUT, XFER_IN} xfer_mode_e;
endpackage

// ---- disc_port_if.sv ----
`timescale 1ns/100ps
interface disc_port_if;
    logic [5:0] ctl_stat_addr_lines;
    logic sel_n;
    logic reg_write_strobe_n;
    logic reg_read_strobe_n;
    logic [7:0] csb_host_out;
    logic csb_host_oe_n;
    logic [7:0] csb_dev_out;
    logic csb_dev_oe_n;
    logic [7:0] sector_host_out;
    logic sector_host_oe_n;
    logic [7:0] sector_dev_out;
    logic sector_dev_oe_n;
    logic inbound_byte_request_n;
    logic inbound_byte_strobe_n;
    logic outbound_byte_request_n;
    logic outbound_byte_strobe_n;
    wire [7:0] ctl_stat_byte_lines = !csb_dev_oe_n ? csb_dev_out :
        (!csb_host_oe_n ? csb_host_out : 8'hff);
    wire [7:0] sector_byte_bus = !sector_dev_oe_n ? sector_dev_out :
        (!sector_host_oe_n ? sector_host_out : 8'hff);
    modport device (
        input ctl_stat_addr_lines, sel_n, reg_write_strobe_n, reg_read_strobe_n,
        input ctl_stat_byte_lines, sector_byte_bus,
        input inbound_byte_strobe_n, outbound_byte_strobe_n,
        output csb_dev_out, csb_dev_oe_n, sector_dev_out, sector_dev_oe_n,
        output inbound_byte_request_n, outbound_byte_request_n
    );
    modport host (
        output ctl_stat_addr_lines, sel_n, reg_write_strobe_n, reg_read_strobe_n,
        input ctl_stat_byte_lines, sector_byte_bus,
        output inbound_byte_strobe_n, outbound_byte_strobe_n,
        output csb_host_out, csb_host_oe_n, sector_host_out, sector_host_oe_n,
        input inbound_byte_request_n, outbound_byte_request_n
    );
endinterface

// ---- disc_port_device.sv ----
// Chosen here: the address map; the Avalon-MM slave port is in disc_port_host.
`timescale 1ns/100ps
`include "disc_port_regs.svh"
module disc_port_device
    import disc_port_pkg::*;
#(
    parameter int PROM_AW = 9
)(
    // clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RESET_N,
    // link
    disc_port_if.device LINK,
    // drive side status
    input wire logic I_SECTOR_REACHED,
    input wire logic I_DATA_ERROR,
    input wire logic [3:0] I_FIELD_SWITCH,
    input wire logic [7:0] I_SELFTEST_INFO,
    input wire logic [7:0] I_DISC_RD_BYTE,
    input wire logic I_DISC_RD_VALID,
    // drive side outputs
    output logic [7:0] O_DISC_WR_BYTE,
    output logic O_DISC_WR_VALID,
    output logic O_FAULT_LAMP_N,
    output logic O_ONLINE_LAMP_N,
    output logic O_LONG_ECC
);
    // ----------
    // pin synchronisers
    // ----------
    localparam int NS = 38;
    logic [NS-1:0] s1, s2, s3;
    wire [NS-1:0] raw = {LINK.ctl_stat_byte_lines, LINK.sector_byte_bus,
        LINK.ctl_stat_addr_lines, I_FIELD_SWITCH, LINK.sel_n, LINK.reg_write_strobe_n,
        LINK.reg_read_strobe_n, LINK.inbound_byte_strobe_n, LINK.outbound_byte_strobe_n,
        I_SECTOR_REACHED, I_DATA_ERROR, 5'h00};
    always_ff @(posedge I_CLOCK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            s1 <= '1;
            s2 <= '1;
            s3 <= '1;
        end
        else
        begin
            s1 <= raw;
            s2 <= s1;
            s3 <= s2;
        end
    end
    wire [7:0] cb2 = s2[37:30];
    wire [7:0] db2 = s2[29:22];
    wire [5:0] ad2 = s2[21:16];
    wire [3:0] sw2 = s2[15:12];
    wire sel_n = s2[11];
    wire wr_n = s2[10];
    wire rd_n = s2[9];
    wire dsin_n = s2[8];
    wire dsout_n = s2[7];
    wire sector_ok = s2[6];
    wire data_err = s2[5];
    wire wr_fall = s3[10] && !wr_n;
    wire dsin_fall = s3[8] && !dsin_n;
    wire dsout_fall = s3[7] && !dsout_n;
    // ----------
    // decode
    // ----------
    wire sel_ok = !sel_n;
    wire hit_ctrl = ad2[5:4] == `ADDR_CTRL_BASE;
    wire hit_prom = (ad2 & `ADDR_PROM_BASE) != 6'h00;
    wire hit_self = ad2 == `ADDR_SELFTEST;
    wire hit_gen = ad2 == `ADDR_GENCTL;
    wire hit_err = ad2 == `ADDR_ERRORS;
    wire hit_ovf = ad2 == `ADDR_OVERFLOW;
    wire hit_ta = ad2 == `ADDR_TEST_A;
    wire hit_tb = ad2 == `ADDR_TEST_B;
    wire do_write = sel_ok && wr_fall;
    wire reading = sel_ok && !rd_n;
    // ----------
    // registers
    // ----------
    logic [7:0] ctrl_regs [`CTRL_REG_COUNT];
    logic [7:0] prom [`PROM_BYTES];
    logic [7:0] gen_ctl, overflow, test_a, test_b, err_flags;
    logic [7:0] remain;
    logic [7:0] rd_data, wr_byte, in_byte;
    logic out_req, in_req, in_full, wr_valid;
    xfer_mode_e mode;
    initial
    begin
        for (int i = 0; i < `PROM_BYTES; i++)
        begin
            prom[i] = 8'(i);
        end
    end
    wire [8:0] prom_idx = {sw2, ad2[4:0]};
    wire [3:0] ci = ad2[3:0];
    wire count_done = remain == 8'h00 && overflow == 8'h00;
    wire out_take = mode == XFER_OUT && out_req && dsout_fall;
    wire in_take = mode == XFER_IN && in_req && dsin_fall;
    wire [7:0] remain_dec = remain == 8'h00 ? 8'h00 : remain - 8'h01;
    wire start_cmd = do_write && hit_ctrl && ci == `CTRL_CMD_REG;
    wire [7:0] err_view = {err_flags[7:6], data_err, err_flags[4:2],
        mode == XFER_IDLE, mode != XFER_IDLE};
    wire [7:0] next_rd = hit_ctrl ? ctrl_regs[ci] :
        hit_prom ? prom[prom_idx] :
        hit_self ? I_SELFTEST_INFO :
        hit_err ? err_view :
        hit_ovf ? overflow :
        hit_ta ? test_a :
        hit_tb ? test_b : 8'h00; // write-only control reads zero
    always_ff @(posedge I_CLOCK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            gen_ctl <= 8'h03;
            overflow <= 8'h00;
            test_a <= 8'h00;
            test_b <= 8'h00;
            err_flags <= 8'h00;
            rd_data <= 8'h00;
            for (int i = 0; i < `CTRL_REG_COUNT; i++)
            begin
                ctrl_regs[i] <= 8'h00;
            end
        end
        else
        begin
            rd_data <= next_rd;
            if (do_write && hit_ctrl)
                ctrl_regs[ci] <= cb2;
            if (do_write && hit_gen)
                gen_ctl <= cb2;
            if (do_write && hit_ta)
                test_a <= cb2;
            if (do_write && hit_tb)
                test_b <= cb2;
            if (do_write && hit_ovf)
                overflow <= cb2;
            else if (remain == 8'h00 && overflow != 8'h00 && (out_take || in_take))
                overflow <= overflow - 8'h01;
        end
    end
    // ----------
    // sector byte handshakes
    // ----------
    wire [2:0] start_dir = cb2[1:0] == 2'h1 ? 3'h1 : (cb2[1:0] == 2'h2 ? 3'h2 : 3'h0);
    always_ff @(posedge I_CLOCK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            mode <= XFER_IDLE;
            remain <= 8'h00;
            out_req <= 1'b0;
            in_req <= 1'b0;
            in_full <= 1'b0;
            wr_valid <= 1'b0;
            wr_byte <= 8'h00;
            in_byte <= 8'h00;
        end
        else
        begin
            wr_valid <= 1'b0;
            if (I_DISC_RD_VALID && !in_full && mode == XFER_IN)
            begin
                in_byte <= I_DISC_RD_BYTE;
                in_full <= 1'b1;
            end
            unique case (mode)
                XFER_IDLE:
                begin
                    out_req <= 1'b0;
                    in_req <= 1'b0;
                    if (start_cmd && start_dir != 3'h0)
                    begin
                        remain <= ctrl_regs[`CTRL_COUNT_REG];
                        mode <= start_dir == 3'h1 ? XFER_OUT : XFER_IN;
                    end
                end
                XFER_OUT:
                begin
                    out_req <= sector_ok && !count_done && !out_take;
                    if (out_take)
                    begin
                        wr_byte <= db2;
                        wr_valid <= 1'b1;
                        remain <= remain_dec;
                    end
                    if (count_done)
                        mode <= XFER_IDLE;
                end
                XFER_IN:
                begin
                    in_req <= in_full && !count_done && !in_take;
                    if (in_take)
                    begin
                        in_full <= 1'b0;
                        remain <= remain_dec;
                    end
                    if (count_done)
                        mode <= XFER_IDLE;
                end
            endcase
        end
    end
    // ----------
    // outputs
    // ----------
    assign LINK.csb_dev_out = rd_data;
    assign LINK.csb_dev_oe_n = !reading;
    assign LINK.sector_dev_out = in_byte;
    assign LINK.sector_dev_oe_n = !(mode == XFER_IN && (in_full || !dsin_n));
    assign LINK.outbound_byte_request_n = !out_req;
    assign LINK.inbound_byte_request_n = !in_req;
    assign O_DISC_WR_BYTE = wr_byte;
    assign O_DISC_WR_VALID = wr_valid;
    assign O_FAULT_LAMP_N = gen_ctl[`GC_FAULT_BIT];
    assign O_ONLINE_LAMP_N = gen_ctl[`GC_ONLINE_BIT];
    assign O_LONG_ECC = gen_ctl[`GC_LONG_ECC_BIT];
endmodule

// ---- disc_port_host.sv ----
`timescale 1ns/100ps
`include "disc_port_regs.svh"
module disc_port_host
    import disc_port_pkg::*;
#(
    parameter int STROBE_CYCLES = 8
)(
    // clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RESET_N,
    // avalon slave
    input wire logic [2:0] I_AV_ADDRESS,
    input wire logic I_AV_READ,
    input wire logic I_AV_WRITE,
    input wire logic [31:0] I_AV_WRITEDATA,
    output logic [31:0] O_AV_READDATA,
    output logic O_AV_WAITREQUEST,
    // link
    disc_port_if.host LINK
);
    typedef enum logic [2:0] {H_IDLE, H_SETUP, H_STROBE, H_HOLD, H_DONE} hstate_e;
    hstate_e st;
    logic [5:0] addr;
    logic [7:0] wdata, rdata, sbyte, rbyte;
    logic is_read, strobe, busy, out_pend, in_pend;
    logic [7:0] cnt;
    logic [1:0] ro1, ro2, ro3;
    logic [7:0] cs1, cs2, sb1, sb2;
    logic dsout, dsin;
    logic [3:0] dcnt;
    logic rd_ack;
    // ----------
    // synchronisers
    // ----------
    always_ff @(posedge I_CLOCK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            ro1 <= 2'h3;
            ro2 <= 2'h3;
            ro3 <= 2'h3;
            cs1 <= 8'h00;
            cs2 <= 8'h00;
            sb1 <= 8'h00;
            sb2 <= 8'h00;
        end
        else
        begin
            ro1 <= {LINK.outbound_byte_request_n, LINK.inbound_byte_request_n};
            ro2 <= ro1;
            ro3 <= ro2;
            cs1 <= LINK.ctl_stat_byte_lines;
            cs2 <= cs1;
            sb1 <= LINK.sector_byte_bus;
            sb2 <= sb1;
        end
    end
    wire out_rq = !ro2[1] && ro3[1];
    wire in_rq = !ro2[0] && ro3[0];
    // ----------
    // avalon decode
    // ----------
    wire av_wr = I_AV_WRITE;
    wire start_op = av_wr && I_AV_ADDRESS == `AV_REG_CMD && !busy;
    wire stall = av_wr && I_AV_ADDRESS == `AV_REG_SECTOR && out_pend;
    wire [7:0] status = {4'h0, out_pend, in_pend, !ro2[1], busy};
    wire [7:0] sel_rd = I_AV_ADDRESS == `AV_REG_ADDR ? {2'h0, addr} :
        I_AV_ADDRESS == `AV_REG_DATA ? rdata :
        I_AV_ADDRESS == `AV_REG_STATUS ? status :
        I_AV_ADDRESS == `AV_REG_SECTOR ? rbyte : 8'h00;
    assign O_AV_WAITREQUEST = stall || (I_AV_READ && !rd_ack);
    always_ff @(posedge I_CLOCK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            O_AV_READDATA <= 32'h0;
            addr <= 6'h00;
            wdata <= 8'h00;
            sbyte <= 8'h00;
            rbyte <= 8'h00;
            in_pend <= 1'b0;
            out_pend <= 1'b0;
            rd_ack <= 1'b0;
        end
        else
        begin
            O_AV_READDATA <= {24'h0, sel_rd};
            rd_ack <= I_AV_READ && !rd_ack;
            if (av_wr && I_AV_ADDRESS == `AV_REG_ADDR)
                addr <= I_AV_WRITEDATA[5:0];
            if (av_wr && I_AV_ADDRESS == `AV_REG_DATA)
                wdata <= I_AV_WRITEDATA[7:0];
            if (av_wr && I_AV_ADDRESS == `AV_REG_SECTOR && !out_pend)
            begin
                sbyte <= I_AV_WRITEDATA[7:0];
                out_pend <= 1'b1;
            end
            else if (dsout && dcnt == 4'h0)
                out_pend <= 1'b0;
            if (dsin && dcnt == 4'h0)
            begin
                rbyte <= sb2;
                in_pend <= 1'b1;
            end
            else if (I_AV_READ && rd_ack && I_AV_ADDRESS == `AV_REG_SECTOR)
                in_pend <= 1'b0;
        end
    end
    // ----------
    // register cycle and byte strobes
    // ----------
    always_ff @(posedge I_CLOCK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            st <= H_IDLE;
            is_read <= 1'b0;
            strobe <= 1'b0;
            busy <= 1'b0;
            cnt <= 8'h00;
            rdata <= 8'h00;
            dsout <= 1'b0;
            dsin <= 1'b0;
            dcnt <= 4'h0;
        end
        else
        begin
            unique case (st)
                H_IDLE:
                    if (start_op)
                    begin
                        is_read <= I_AV_WRITEDATA[1:0] == `AV_CMD_READ;
                        busy <= 1'b1;
                        st <= H_SETUP;
                        cnt <= 8'(STROBE_CYCLES);
                    end
                H_SETUP:
                begin
                    strobe <= 1'b1;
                    st <= H_STROBE;
                end
                H_STROBE:
                begin
                    cnt <= cnt - 8'h01;
                    if (cnt == 8'h01)
                    begin
                        rdata <= is_read ? cs2 : rdata;
                        strobe <= 1'b0;
                        st <= H_HOLD;
                    end
                end
                H_HOLD:
                    st <= H_DONE;
                H_DONE:
                begin
                    busy <= 1'b0;
                    st <= H_IDLE;
                end
            endcase
            if (dsout || dsin)
            begin
                dcnt <= dcnt - 4'h1;
                if (dcnt == 4'h0)
                begin
                    dsout <= 1'b0;
                    dsin <= 1'b0;
                end
            end
            else if (out_rq && out_pend)
            begin
                dsout <= 1'b1;
                dcnt <= 4'h3;
            end
            else if (in_rq && !in_pend)
            begin
                dsin <= 1'b1;
                dcnt <= 4'h3;
            end
        end
    end
    assign LINK.ctl_stat_addr_lines = addr;
    assign LINK.sel_n = !busy;
    assign LINK.reg_write_strobe_n = !(strobe && !is_read);
    assign LINK.reg_read_strobe_n = !(strobe && is_read);
    assign LINK.csb_host_out = wdata;
    assign LINK.csb_host_oe_n = !(busy && !is_read);
    assign LINK.sector_host_out = sbyte;
    assign LINK.sector_host_oe_n = !out_pend;
    assign LINK.outbound_byte_strobe_n = !dsout;
    assign LINK.inbound_byte_strobe_n = !dsin;
endmodule

// ---- disc_port_props.sv ----
`timescale 1ns/100ps
module disc_port_props #(
    parameter int STROBE_CYCLES = 8
)(
    // clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RESET_N,
    // register lines
    input wire logic [5:0] ctl_stat_addr_lines,
    input wire logic sel_n,
    input wire logic reg_write_strobe_n,
    input wire logic reg_read_strobe_n,
    input wire logic csb_host_oe_n,
    input wire logic csb_dev_oe_n,
    // sector lines
    input wire logic sector_host_oe_n,
    input wire logic sector_dev_oe_n,
    input wire logic inbound_byte_request_n,
    input wire logic inbound_byte_strobe_n,
    input wire logic outbound_byte_request_n,
    input wire logic outbound_byte_strobe_n
);
    logic [7:0] low_cnt;
    logic [5:0] rd_hist;
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RESET_N);
    always_ff @(posedge I_CLOCK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            low_cnt <= 8'h00;
            rd_hist <= 6'h00;
        end
        else
        begin
            low_cnt <= reg_read_strobe_n ? 8'h00 : low_cnt + 8'h01;
            rd_hist <= {rd_hist[4:0], !sel_n && !reg_read_strobe_n};
        end
    end
    // ----------
    // assertions
    // ----------
    a_read_drive_only: assert property (!csb_dev_oe_n |-> (|rd_hist))
        else $error("device drives status bus outside a read");
    a_sel_gates_strobe: assert property (!(reg_read_strobe_n && reg_write_strobe_n) |-> !sel_n)
        else $error("register strobe without select");
    a_read_strobe_width: assert property ($rose(reg_read_strobe_n) |-> low_cnt == STROBE_CYCLES)
        else $error("read strobe width wrong");
    a_addr_held: assert property (!sel_n && $past(!sel_n) |-> $stable(ctl_stat_addr_lines))
        else $error("address moved while selected");
    a_no_bus_clash: assert property (!csb_host_oe_n |-> csb_dev_oe_n)
        else $error("both ends drive status bus");
    a_out_after_req: assert property ($fell(outbound_byte_strobe_n) |-> !outbound_byte_request_n)
        else $error("outbound strobe without request");
    a_out_strobe_len: assert property ($fell(outbound_byte_strobe_n) |-> !outbound_byte_strobe_n[*4] ##1 outbound_byte_strobe_n)
        else $error("outbound strobe length wrong");
    a_out_req_drop: assert property ($fell(outbound_byte_strobe_n) |-> ##[1:6] outbound_byte_request_n)
        else $error("outbound request not dropped");
    a_out_host_data: assert property (!outbound_byte_strobe_n |-> !sector_host_oe_n)
        else $error("host not driving byte during strobe");
    a_in_after_req: assert property ($fell(inbound_byte_strobe_n) |-> !inbound_byte_request_n)
        else $error("inbound strobe without request");
    a_in_dev_data: assert property (!inbound_byte_strobe_n |-> !sector_dev_oe_n && sector_host_oe_n)
        else $error("device not driving inbound byte");
    c_reg_write: cover property ($fell(reg_write_strobe_n));
    c_reg_read: cover property ($fell(reg_read_strobe_n));
    c_out_byte: cover property ($fell(outbound_byte_strobe_n));
    c_in_byte: cover property ($fell(inbound_byte_strobe_n));
endmodule

// ---- testbench.sv ----
`timescale 1ns/100ps
`include "disc_port_regs.svh"
module testbench;
    import disc_port_pkg::*;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [2:0] av_address = 3'h0;
    logic av_read = 1'b0;
    logic av_write = 1'b0;
    logic [31:0] av_wdata = 32'h0;
    logic [31:0] av_rdata;
    logic av_wait;
    logic reached = 1'b0;
    logic data_err = 1'b0;
    logic [3:0] field_sw = 4'h0;
    logic [7:0] st_info = 8'h00;
    logic [7:0] rd_byte = 8'h00;
    logic rd_valid = 1'b0;
    logic [7:0] wr_byte;
    logic wr_valid, fault_n, online_n, long_ecc;
    logic [7:0] got_q[$];
    int err_count = 0;
    int tests_run = 0;
    always #5 clock = !clock;
    disc_port_if link ();
    disc_port_host #(.STROBE_CYCLES(8)) disc_port_host_i (.I_CLOCK(clock), .I_RESET_N(reset_n),
        .I_AV_ADDRESS(av_address), .I_AV_READ(av_read), .I_AV_WRITE(av_write),
        .I_AV_WRITEDATA(av_wdata), .O_AV_READDATA(av_rdata), .O_AV_WAITREQUEST(av_wait),
        .LINK(link));
    disc_port_device disc_port_device_i (.I_CLOCK(clock), .I_RESET_N(reset_n), .LINK(link),
        .I_SECTOR_REACHED(reached), .I_DATA_ERROR(data_err), .I_FIELD_SWITCH(field_sw),
        .I_SELFTEST_INFO(st_info), .I_DISC_RD_BYTE(rd_byte), .I_DISC_RD_VALID(rd_valid),
        .O_DISC_WR_BYTE(wr_byte), .O_DISC_WR_VALID(wr_valid), .O_FAULT_LAMP_N(fault_n),
        .O_ONLINE_LAMP_N(online_n), .O_LONG_ECC(long_ecc));
    disc_port_props #(.STROBE_CYCLES(8)) disc_port_props_i (.I_CLOCK(clock),
        .I_RESET_N(reset_n), .ctl_stat_addr_lines(link.ctl_stat_addr_lines),
        .sel_n(link.sel_n), .reg_write_strobe_n(link.reg_write_strobe_n),
        .reg_read_strobe_n(link.reg_read_strobe_n), .csb_host_oe_n(link.csb_host_oe_n),
        .csb_dev_oe_n(link.csb_dev_oe_n), .sector_host_oe_n(link.sector_host_oe_n),
        .sector_dev_oe_n(link.sector_dev_oe_n),
        .inbound_byte_request_n(link.inbound_byte_request_n),
        .inbound_byte_strobe_n(link.inbound_byte_strobe_n),
        .outbound_byte_request_n(link.outbound_byte_request_n),
        .outbound_byte_strobe_n(link.outbound_byte_strobe_n));
    always @(negedge clock)
    begin
        if (wr_valid === 1'b1)
        begin
            got_q.push_back(wr_byte);
        end
    end
    // ----------
    // shared tasks
    // ----------
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
        begin
            $display("ALL CHECKS OK");
        end
        else
        begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic guard(input int n);
        if (n > 300)
        begin
            err_count++;
            report_and_stop;
        end
    endtask
    task automatic av_cycle(input logic [2:0] a, input logic wr, input logic [31:0] d,
        output logic [31:0] q);
        int n = 0;
        @(posedge clock);
        av_address <= a;
        av_write <= wr;
        av_read <= !wr;
        av_wdata <= d;
        @(negedge clock);
        while (av_wait !== 1'b0)
        begin
            n++;
            guard(n);
            @(negedge clock);
        end
        q = av_rdata;
        @(posedge clock);
        av_write <= 1'b0;
        av_read <= 1'b0;
    endtask
    task automatic av_wr(input logic [2:0] a, input logic [31:0] d);
        logic [31:0] q;
        av_cycle(a, 1'b1, d, q);
    endtask
    task automatic av_rd(input logic [2:0] a, output logic [31:0] q);
        av_cycle(a, 1'b0, 32'h0, q);
    endtask
    task automatic poll(input int b, input logic v);
        logic [31:0] q;
        int n = 0;
        do
        begin
            av_rd(`AV_REG_STATUS, q);
            n++;
            guard(n);
        end
        while (q[b] !== v);
    endtask
    task automatic dev_wr(input logic [5:0] a, input logic [7:0] d);
        av_wr(`AV_REG_ADDR, {26'h0, a});
        av_wr(`AV_REG_DATA, {24'h0, d});
        av_wr(`AV_REG_CMD, {30'h0, `AV_CMD_WRITE});
        poll(0, 1'b0);
    endtask
    task automatic dev_rd(input logic [5:0] a, output logic [7:0] d);
        logic [31:0] q;
        av_wr(`AV_REG_ADDR, {26'h0, a});
        av_wr(`AV_REG_CMD, {30'h0, `AV_CMD_READ});
        poll(0, 1'b0);
        av_rd(`AV_REG_DATA, q);
        d = q[7:0];
    endtask
    task automatic lamps(input logic [2:0] e);
        check("fault lamp", fault_n, e[0]);
        check("online lamp", online_n, e[1]);
        check("long ecc", long_ecc, e[2]);
    endtask
    // ----------
    // scenarios
    // ----------
    task automatic t_reset;
        @(negedge clock);
        lamps(3'b011);
        check("idle status bus", link.ctl_stat_byte_lines, 8'hff);
        check("out request", link.outbound_byte_request_n, 1);
        check("in request", link.inbound_byte_request_n, 1);
    endtask
    task automatic t_genctl;
        dev_wr(`ADDR_GENCTL, 8'h04);
        lamps(3'b100);
        dev_wr(`ADDR_GENCTL, 8'h03);
        lamps(3'b011);
    endtask
    task automatic t_regs;
        logic [7:0] d;
        @(posedge clock);
        st_info <= 8'ha5;
        dev_wr(`ADDR_SELFTEST, 8'h5a);
        dev_rd(`ADDR_SELFTEST, d);
        check("self test", d, 8'ha5);
        dev_wr(`ADDR_OVERFLOW, 8'h3c);
        dev_wr(6'h03, 8'h96);
        dev_rd(`ADDR_OVERFLOW, d);
        check("overflow reg", d, 8'h3c);
        dev_rd(6'h03, d);
        check("controller reg", d, 8'h96);
    endtask
    task automatic t_errors;
        logic [7:0] d;
        @(posedge clock);
        data_err <= 1'b1;
        dev_rd(`ADDR_ERRORS, d);
        check("data error on", d[5], 1);
        check("transfer idle", d[1], 1);
        @(posedge clock);
        data_err <= 1'b0;
        dev_rd(`ADDR_ERRORS, d);
        check("data error off", d[5], 0);
    endtask
    task automatic t_prom;
        logic [3:0] sw[4] = '{4'h0, 4'h1, 4'h3, 4'h2};
        logic [5:0] ad[4] = '{6'h20, 6'h25, 6'h3f, 6'h20};
        logic [7:0] ex[4] = '{8'h00, 8'h25, 8'h7f, 8'h40};
        logic [7:0] d;
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clock);
            field_sw <= sw[i];
            dev_rd(ad[i], d);
            check("prom byte", d, ex[i]);
        end
    endtask
    task automatic t_out;
        logic [7:0] d;
        int n = 0;
        got_q.delete();
        dev_wr(`ADDR_OVERFLOW, 8'h01);
        dev_wr(`CTRL_COUNT_REG, 8'h02);
        av_wr(`AV_REG_SECTOR, 32'hc1);
        dev_wr(`CTRL_CMD_REG, 8'h01);
        repeat (30) @(negedge clock);
        check("early out request", link.outbound_byte_request_n, 1);
        check("early bytes", got_q.size(), 0);
        @(posedge clock);
        reached <= 1'b1;
        av_wr(`AV_REG_SECTOR, 32'hc2);
        av_wr(`AV_REG_SECTOR, 32'hc3);
        while (got_q.size() < 3)
        begin
            @(negedge clock);
            n++;
            guard(n);
        end
        repeat (40) @(negedge clock);
        check("out byte count", got_q.size(), 3);
        for (int i = 0; i < 3; i++)
        begin
            check("out byte", got_q[i], 8'hc1 + i[7:0]);
        end
        check("out request done", link.outbound_byte_request_n, 1);
        @(posedge clock);
        reached <= 1'b0;
        dev_rd(`ADDR_OVERFLOW, d);
        check("overflow spent", d, 8'h00);
    endtask
    task automatic t_in;
        logic [7:0] vals[2] = '{8'h81, 8'h7e};
        logic [31:0] q;
        dev_wr(`ADDR_OVERFLOW, 8'h00);
        dev_wr(`CTRL_COUNT_REG, 8'h02);
        dev_wr(`CTRL_CMD_REG, 8'h02);
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clock);
            rd_byte <= vals[i];
            rd_valid <= 1'b1;
            @(posedge clock);
            rd_valid <= 1'b0;
            poll(2, 1'b1);
            av_rd(`AV_REG_SECTOR, q);
            check("in byte", q[7:0], vals[i]);
        end
        repeat (20) @(negedge clock);
        check("in request done", link.inbound_byte_request_n, 1);
    endtask
    initial
    begin
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        t_reset;
        t_genctl;
        t_regs;
        t_errors;
        t_prom;
        t_out;
        t_in;
        report_and_stop;
    end
endmodule
